// ### rtl/sdram_configuration_pkg.sv
package sdram_configuration_pkg;
    // Register offsets (byte addresses, word aligned)
    localparam logic [3:0]  SDRAM_CONFIGURATION_CONFIG_OFS  = 4'h0;
    localparam logic [3:0]  SDRAM_CONFIGURATION_DECODE_OFS  = 4'h4;
    localparam logic [31:0] SDRAM_CONFIGURATION_RESET_VALUE = 32'h00000200;
    // Writable bit mask: type, termination, write termination, latencies, width, banks, page
    localparam logic [31:0] SDRAM_CONFIGURATION_WRITE_MASK  = 32'heec1ff77;
    // Field positions (low bit)
    localparam int SDRAM_CONFIGURATION_TYPE_LSB   = 29;
    localparam int SDRAM_CONFIGURATION_TERM_LSB   = 25;
    localparam int SDRAM_CONFIGURATION_WTERM_LSB  = 22;
    localparam int SDRAM_CONFIGURATION_WLAT_LSB   = 14;
    localparam int SDRAM_CONFIGURATION_WIDTH_LSB  = 12;
    localparam int SDRAM_CONFIGURATION_RLAT_LSB   = 8;
    localparam int SDRAM_CONFIGURATION_BANK_LSB   = 4;
    localparam int SDRAM_CONFIGURATION_CS_LSB     = 3;
    localparam int SDRAM_CONFIGURATION_PAGE_LSB   = 0;
    localparam logic [2:0] SDRAM_CONFIGURATION_TYPE_DDR3   = 3'h3;
    localparam logic [2:0] SDRAM_CONFIGURATION_TERM_MAXOK  = 3'h5;
    localparam logic [1:0] SDRAM_CONFIGURATION_WTERM_RSVD  = 2'h3;
    localparam logic [1:0] SDRAM_CONFIGURATION_WIDTH_MAXOK = 2'h2;
    localparam logic [4:0] SDRAM_CONFIGURATION_WLAT_BASE   = 5'h05;
    localparam logic [4:0] SDRAM_CONFIGURATION_RLAT_EVEN   = 5'h04;
    localparam logic [4:0] SDRAM_CONFIGURATION_RLAT_ODD    = 5'h0c;
    // Decoded settings handed to the sequencer
    typedef struct packed {
        logic [2:0] term_sel;
        logic [1:0] wterm_sel;
        logic [4:0] write_latency;
        logic [6:0] bus_width_bits;
        logic [4:0] read_latency;
        logic [2:0] internal_bank_count;
        logic       chip_select_count;
        logic [2:0] page_size_select;
        logic       valid;
    } sdram_configuration_settings_type;
endpackage : sdram_configuration_pkg

// ### rtl/sdram_configuration_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_configuration_decode (
    input  wire logic [31:0]                 cfg,
    output sdram_configuration_pkg::sdram_configuration_settings_type    settings
);
    logic [3:0] rl;
    logic [1:0] bw;
    logic [1:0] wt;
    logic [2:0] tm;
    logic [2:0] ty;
    logic       rl_ok;
    assign rl = cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_RLAT_LSB +: 4];
    assign bw = cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_WIDTH_LSB +: 2];
    assign wt = cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_WTERM_LSB +: 2];
    assign tm = cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_TERM_LSB +: 3];
    assign ty = cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_TYPE_LSB +: 3];
    // Even read-latency codes 2..14 and odd codes 1..9 are legal
    assign rl_ok = rl[0] ? (rl <= 4'h9) : (rl != 4'h0);
    // Field decode into cycle counts and widths
    always_comb begin
        settings.term_sel            = tm;
        settings.wterm_sel           = wt;
        settings.write_latency       = sdram_configuration_pkg::SDRAM_CONFIGURATION_WLAT_BASE
                                       + {2'h0, cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_WLAT_LSB +: 3]};
        settings.read_latency        = rl[0]
            ? sdram_configuration_pkg::SDRAM_CONFIGURATION_RLAT_ODD + {2'h0, rl[3:1]}
            : sdram_configuration_pkg::SDRAM_CONFIGURATION_RLAT_EVEN + {2'h0, rl[3:1]};
        case (bw)
            2'h0:    settings.bus_width_bits = 7'h40;
            2'h1:    settings.bus_width_bits = 7'h20;
            2'h2:    settings.bus_width_bits = 7'h10;
            default: settings.bus_width_bits = 7'h00;
        endcase
        settings.internal_bank_count = cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_BANK_LSB +: 3];
        settings.chip_select_count   = cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_CS_LSB];
        settings.page_size_select    = cfg[sdram_configuration_pkg::SDRAM_CONFIGURATION_PAGE_LSB +: 3];
        settings.valid = (ty == sdram_configuration_pkg::SDRAM_CONFIGURATION_TYPE_DDR3)
                         && (tm <= sdram_configuration_pkg::SDRAM_CONFIGURATION_TERM_MAXOK)
                         && (wt != sdram_configuration_pkg::SDRAM_CONFIGURATION_WTERM_RSVD)
                         && (bw <= sdram_configuration_pkg::SDRAM_CONFIGURATION_WIDTH_MAXOK) && rl_ok;
    end
endmodule : sdram_configuration_decode
`default_nettype wire

// ### rtl/sdram_configuration_regs.sv
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sdram_configuration_regs (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic [3:0]                  address,
    input  wire logic                        read,
    input  wire logic                        write,
    input  wire logic [31:0]                 writedata,
    input  wire logic [3:0]                  byteenable,
    output logic [31:0]                      readdata,
    output logic                             waitrequest,
    output logic                             init_start,
    output sdram_configuration_pkg::sdram_configuration_settings_type    settings
);
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [31:0] be_mask;
    logic        ack_q;
    logic        sel_cfg;
    logic        wr_fire;
    sdram_configuration_pkg::sdram_configuration_settings_type dec;

    // Byte enables widened to bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    assign be_mask   = lane_mask(byteenable);
    assign sel_cfg   = (address == sdram_configuration_pkg::SDRAM_CONFIGURATION_CONFIG_OFS);
    // One wait cycle per access; answer on the second edge
    assign waitrequest = (read || write) && !ack_q;
    assign wr_fire   = write && ack_q;
    // Only writable bits in enabled lanes change
    assign cfg_d = (cfg_q & ~(be_mask & sdram_configuration_pkg::SDRAM_CONFIGURATION_WRITE_MASK))
                 | (writedata & be_mask & sdram_configuration_pkg::SDRAM_CONFIGURATION_WRITE_MASK);
    // Access acknowledge toggle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read || write) && !ack_q;
        end
    end

    // Configuration register storage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_q <= sdram_configuration_pkg::SDRAM_CONFIGURATION_RESET_VALUE;
        end else if (wr_fire && sel_cfg) begin
            cfg_q <= cfg_d;
        end
    end

    // A write touching width or read-latency lane starts initialization
    always_ff @(posedge clk) begin
        if (!nrst) begin
            init_start <= 1'b0;
        end else begin
            init_start <= wr_fire && sel_cfg && byteenable[1];
        end
    end

    // Read data: config, decoded view, else zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            readdata <= 32'h00000000;
        end else if (read && !ack_q) begin
            if (sel_cfg) begin
                readdata <= cfg_q & sdram_configuration_pkg::SDRAM_CONFIGURATION_WRITE_MASK;
            end else if (address == sdram_configuration_pkg::SDRAM_CONFIGURATION_DECODE_OFS) begin
                readdata <= {dec.valid, 2'h0, dec.read_latency, 3'h0,
                             dec.bus_width_bits, 3'h0, dec.write_latency, 6'h00};
            end else begin
                readdata <= 32'h00000000;
            end
        end
    end

    // Field decode for the sequencer
    sdram_configuration_decode u_decode (
        .cfg      (cfg_q),
        .settings (dec)
    );

    // Settings registered toward the command sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            settings <= '0;
        end else begin
            settings <= dec;
        end
    end

    rsvd_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        (cfg_q & ~sdram_configuration_pkg::SDRAM_CONFIGURATION_WRITE_MASK) == 32'h0)
        else $error("reserved bits set");
    write_takes_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_fire && sel_cfg && (&byteenable))
        |=> cfg_q == ($past(writedata) & sdram_configuration_pkg::SDRAM_CONFIGURATION_WRITE_MASK))
        else $error("write not stored");
    init_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_fire && sel_cfg && byteenable[1]) |=> init_start)
        else $error("init not started");
    init_cause_a: assert property (@(posedge clk) disable iff (!nrst)
        init_start |-> $past(wr_fire && sel_cfg))
        else $error("spurious init");
    wlat_range_a: assert property (@(posedge clk) disable iff (!nrst)
        dec.write_latency >= 5'h05 && dec.write_latency <= 5'h0c)
        else $error("write latency out of range");
    wterm_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !(wr_fire && sel_cfg) |=> $stable(cfg_q[23:22]))
        else $error("write termination moved");
    term_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !(wr_fire && sel_cfg) |=> $stable(cfg_q[27:25]))
        else $error("termination moved");
    settings_track_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_fire && sel_cfg) |-> ##3 settings == dec)
        else $error("settings lag");
    answer_time_a: assert property (@(posedge clk) disable iff (!nrst)
        (read || write) && !ack_q |=> !waitrequest)
        else $error("answer late");
    cfg_write_c: cover property (@(posedge clk) wr_fire && sel_cfg);
    cfg_read_c: cover property (@(posedge clk) read && !waitrequest && sel_cfg);
    init_c: cover property (@(posedge clk) init_start);
    valid_c: cover property (@(posedge clk) settings.valid);
endmodule : sdram_configuration_regs
`default_nettype wire

// ### tb/sdram_configuration_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_configuration_seq_model (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        init_start,
    input  wire sdram_configuration_pkg::sdram_configuration_settings_type settings,
    output int                               starts
);
    // Sequencer stand-in: counts initialization starts it is asked for
    always @(posedge clk) begin
        if (!nrst) starts <= 0;
        else if (init_start === 1'b1) starts <= starts + 1;
    end
endmodule : sdram_configuration_seq_model
`default_nettype wire

// ### tb/tb_ddr3_sdram_config_register.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ddr3_sdram_config_register;
    logic clk = 0, nrst = 0, read = 0, write = 0, init_start, waitrequest;
    logic [3:0] address = 4'h0, byteenable = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q, m, v, r;
    sdram_configuration_pkg::sdram_configuration_settings_type settings;
    int miscompares = 0, comparisons = 0, starts, exp_starts = 0, rl, wl, cl;
    logic [31:0] seed = 32'h00014aa4;
    int cl_codes[12] = '{2, 4, 6, 8, 10, 12, 14, 1, 3, 5, 7, 9};
    sdram_configuration_regs sdram_configuration_regs_i (.clk(clk), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .init_start(init_start), .settings(settings));
    sdram_configuration_seq_model sdram_configuration_seq_model_i (.clk(clk), .nrst(nrst), .init_start(init_start),
        .settings(settings), .starts(starts));
    // Clock of 50 ns period
    always #25 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        logic w;
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        w = 1'b1;
        n = 0;
        while (w !== 1'b0) begin
            @(posedge clk);
            w = waitrequest;
            rd = readdata;
            n++;
            if (n > 20) begin
                miscompares++;
                end_of_test();
            end
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        m = 32'h2 << 8;
        bus(4'h0, 0, 0, 0, q);
        chk("reset value", q, m);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            v = rnd();
            v[31:29] = 3'h3;
            v[27:25] = 3'(rnd() % 6);
            v[23:22] = 2'(rnd() % 3);
            v[13:12] = 2'(rnd() % 3);
            v[11:8] = 4'(cl_codes[rnd() % 12]);
            r = rnd();
            bus(4'h0, 1, v, r[3:0], q);
            if (r[1]) exp_starts++;
            for (int b = 0; b < 4; b++)
                if (r[b]) m[8*b+:8] = (v[8*b+:8] & 8'(32'heec1ff77 >> 8*b));
            bus(4'h0, 0, 0, 0, q);
            chk("config", q, m);
            cl = m[11:8];
            rl = cl[0] ? (cl - 1) / 2 + 12 : cl / 2 + 4;
            wl = m[16:14] + 5;
            bus(4'h4, 0, 0, 0, q);
            chk("decoded", q & 32'h1f1fc7c0, (rl << 24) | ((64 >> m[13:12]) << 14) | (wl << 6));
            chk("write latency", 32'(settings.write_latency), wl);
            chk("read latency", 32'(settings.read_latency), rl);
        end
        $display("test random fields done");
        bus(4'h8, 1, 32'hffffffff, 4'hf, q);
        bus(4'h8, 0, 0, 0, q);
        chk("unmapped", q, 0);
        bus(4'h0, 0, 0, 0, q);
        chk("config kept", q, m);
        repeat (3) @(posedge clk);
        chk("init starts", starts, exp_starts);
        $display("test unmapped and init done");
        end_of_test();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule : tb_ddr3_sdram_config_register
`default_nettype wire
